// File: sim/adc_trigger_pacer_logic_test.sv
// Self-checking bench for the conversion trigger and pacer logic
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_pacer_logic_test;
   logic               clk = 1'b0, rst_n = 1'b0, trig, gate, fclk = 1'b0;
   logic               fgate = 1'b1, en = 1'b1, fext = 1'b1, conv, pacer, first;
   atp_pkg::atp_src_e  src = atp_pkg::ATP_SRC_NONE;
   atp_pkg::atp_mode_e mode = atp_pkg::ATP_MODE_PULSE;
   atp_pkg::atp_count_t rl = 16'h0002, rh = 16'h0003, rf = 16'h0001;
   logic [7:0]         starts = 8'h00, pulses = 8'h00, fpulses = 8'h00, got;
   int                 errors = 0, n_checks = 0, cycles = 0;
   always #5 clk = ~clk;
   // Count output pulses, pace the first counter pin, bound the run
   always @(posedge clk)
   begin
      cycles++;
      starts <= starts + {7'h00, conv === 1'b1};
      pulses <= pulses + {7'h00, pacer === 1'b1};
      fpulses <= fpulses + {7'h00, first === 1'b1};
      fclk <= #1 cycles[1];
      if (cycles > 6000)
      begin
         errors++;
         complete_run();
      end
   end
   atp_trig_source atp_trig_source_inst (.i_clk(clk), .o_trigger(trig), .o_gate(gate));
   atp_trigger_pacer atp_trigger_pacer_inst (.I_SYS_CLK(clk), .I_RESETN(rst_n),
      .i_external_conversion_trigger(trig), .i_external_trigger_gate(gate),
      .i_first_counter_clock_input(fclk), .i_first_counter_gate_input(fgate),
      .i_trigger_source(src), .i_pacer_enable(en), .i_pacer_low_reload(rl),
      .i_pacer_high_reload(rh), .i_first_reload(rf), .i_first_clock_external(fext),
      .i_first_mode(mode), .o_conversion_start(conv), .o_pacer_output(pacer),
      .o_first_counter_output(first));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // Send n trigger edges and report the starts they made
   task automatic fire(input int n, output logic [7:0] cnt);
      logic [7:0] s0;
      s0 = starts;
      repeat (n) atp_trig_source_inst.pulse(2, 2);
      repeat (10) @(posedge clk);
      cnt = starts - s0;
   endtask
   task automatic t_ext;
      @(posedge clk) #1 src = atp_pkg::ATP_SRC_EXTERNAL;
      repeat (8) @(posedge clk);
      fire(1, got);
      check("single_start", got, 8'h01);
      fire(3, got);
      check("burst_starts", got, 8'h03);
   endtask
   task automatic t_gate_low;
      atp_trig_source_inst.set_gate(1'b0);
      repeat (8) @(posedge clk);
      fire(2, got);
      check("gated_starts", got, 8'h00);
      atp_trig_source_inst.set_gate(1'b1);
   endtask
   task automatic t_other_src;
      atp_pkg::atp_src_e s;
      @(posedge clk) #1 en = 1'b0;
      for (int i = 0; i < 4; i += 1)
      begin
         s = atp_pkg::atp_src_e'(i);
         if (s == atp_pkg::ATP_SRC_EXTERNAL)
            continue;
         @(posedge clk) #1 src = s;
         fire(1, got);
         check("other_src_starts", got, 8'h00);
      end
   endtask
   // Ten pacer periods of 2 x 3 timebase ticks (60 clocks each) in 600 clocks
   task automatic t_pacer_on;
      logic [7:0] p0, s0;
      @(posedge clk) #1 src = atp_pkg::ATP_SRC_PACER;
      en = 1'b1;
      repeat (120) @(posedge clk);
      p0 = pulses;
      s0 = starts;
      repeat (600) @(posedge clk);
      check("pacer_pulses", pulses - p0, 8'h0A);
      check("pacer_starts", starts - s0, 8'h0A);
   endtask
   // First counter: rate 2 on a 4-clock pin clock, on the 1 MHz clock, then events
   task automatic t_first;
      logic [7:0] f0;
      @(posedge clk) #1 rf = 16'h0002;
      mode = atp_pkg::ATP_MODE_PULSE;
      repeat (40) @(posedge clk);
      f0 = fpulses;
      repeat (400) @(posedge clk);
      check("first_pin_pulses", fpulses - f0, 8'h32);
      #1 fext = 1'b0;
      repeat (400) @(posedge clk);
      f0 = fpulses;
      repeat (800) @(posedge clk);
      check("first_int_pulses", fpulses - f0, 8'h04);
      #1 fgate = 1'b0;
      mode = atp_pkg::ATP_MODE_EVENT;
      fext = 1'b1;
      rf = 16'h0003;
      repeat (8) @(posedge clk);
      check("first_event_idle", {7'h00, first}, 8'h00);
      #1 fgate = 1'b1;
      repeat (40) @(posedge clk);
      check("first_event_done", {7'h00, first}, 8'h01);
      #1 fgate = 1'b0;
      repeat (8) @(posedge clk);
      check("first_event_clear", {7'h00, first}, 8'h00);
   endtask
   task automatic t_pacer_off;
      logic [7:0] p0, s0;
      @(posedge clk) #1 en = 1'b0;
      src = atp_pkg::ATP_SRC_PACER;
      repeat (4) @(posedge clk);
      p0 = pulses;
      s0 = starts;
      repeat (300) @(posedge clk);
      check("pacer_pulses_off", pulses - p0, 8'h00);
      check("pacer_starts_off", starts - s0, 8'h00);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      t_ext();
      t_gate_low();
      t_other_src();
      t_pacer_on();
      t_first();
      t_pacer_off();
      complete_run();
   end
endmodule
`default_nettype wire

// File: sim/atp_trig_source.sv
// External trigger source and gate wiring model
`timescale 1ns/1ps
`default_nettype none
module atp_trig_source
(
   input  wire logic i_clk,
   output logic      o_trigger,
   output logic      o_gate
);
   // Idle: trigger low, gate held high
   initial
   begin
      o_trigger = 1'b0;
      o_gate    = 1'b1;
   end
   // Gate level held by the far side
   task automatic set_gate(input logic level);
      @(posedge i_clk) #1 o_gate = level;
   endtask
   // One rising edge, high and low for the given cycles
   task automatic pulse(input int hi, input int lo);
      @(posedge i_clk) #1 o_trigger = 1'b1;
      repeat (hi) @(posedge i_clk);
      #1 o_trigger = 1'b0;
      repeat (lo - 1) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// File: sim/atp_trigger_pacer_monitor.sv
// Port checker for the conversion trigger and pacer logic
`timescale 1ns/1ps
`default_nettype none
module atp_trigger_pacer_chk
(
   input wire logic               I_SYS_CLK,
   input wire logic               I_RESETN,
   input wire logic               i_external_conversion_trigger,
   input wire logic               i_external_trigger_gate,
   input wire atp_pkg::atp_src_e  i_trigger_source,
   input wire logic               i_pacer_enable,
   input wire atp_pkg::atp_mode_e i_first_mode,
   input wire logic               o_conversion_start,
   input wire logic               o_pacer_output,
   input wire logic               o_first_counter_output
);
   localparam atp_pkg::atp_src_e EXT = atp_pkg::ATP_SRC_EXTERNAL;
   localparam atp_pkg::atp_src_e PAC = atp_pkg::ATP_SRC_PACER;
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   // Gated trigger edge, then the gate and source held through the sync stages
   sequence s_ext_edge;
      $rose(i_external_conversion_trigger) && i_external_trigger_gate && i_trigger_source == EXT;
   endsequence
   sequence s_ext_held;
      (i_external_trigger_gate && i_trigger_source == EXT) [*2];
   endsequence
   property p_ext_start;
      s_ext_edge ##1 s_ext_held |-> ##[1:3] o_conversion_start;
   endproperty
   a_ext_start: assert property (p_ext_start) else $error("trigger edge gave no start");
   property p_gate_block;
      (!i_external_trigger_gate && i_trigger_source == EXT) [*6] |-> !o_conversion_start;
   endproperty
   a_gate_block: assert property (p_gate_block) else $error("start while gate low");
   property p_src_only;
      o_conversion_start |-> ($past(i_trigger_source) == EXT || $past(i_trigger_source) == PAC);
   endproperty
   a_src_only: assert property (p_src_only) else $error("start from unselected source");
   property p_pacer_start;
      o_pacer_output && i_trigger_source == PAC |=> o_conversion_start;
   endproperty
   a_pacer_start: assert property (p_pacer_start) else $error("pacer edge gave no start");
   property p_pacer_width;
      o_pacer_output |=> !o_pacer_output [*8];
   endproperty
   a_pacer_width: assert property (p_pacer_width) else $error("pacer pulse too close");
   property p_pacer_gate;
      !i_pacer_enable [*2] |=> !o_pacer_output;
   endproperty
   a_pacer_gate: assert property (p_pacer_gate) else $error("pacer pin pulsed while off");
   property p_start_width;
      o_conversion_start |=> !o_conversion_start;
   endproperty
   a_start_width: assert property (p_start_width) else $error("start wider than a cycle");
   property p_first_pulse;
      o_first_counter_output && i_first_mode == atp_pkg::ATP_MODE_PULSE |=> !o_first_counter_output;
   endproperty
   a_first_pulse: assert property (p_first_pulse) else $error("first counter pulse too wide");
endmodule
bind atp_trigger_pacer atp_trigger_pacer_chk atp_trigger_pacer_chk_inst (.I_SYS_CLK, .I_RESETN,
   .i_external_conversion_trigger, .i_external_trigger_gate, .i_trigger_source, .i_pacer_enable,
   .i_first_mode, .o_conversion_start, .o_pacer_output, .o_first_counter_output);
`default_nettype wire

// File: verilog/atp_pkg.sv
// Types for the conversion trigger and pacer logic
package atp_pkg;
   // Conversion trigger source selected by software
   typedef enum logic [1:0]
   {
      ATP_SRC_NONE,
      ATP_SRC_PACER,
      ATP_SRC_EXTERNAL,
      ATP_SRC_SPARE
   } atp_src_e;

   // First counter operating mode
   typedef enum logic
   {
      ATP_MODE_EVENT,
      ATP_MODE_PULSE
   } atp_mode_e;

   typedef logic [15:0] atp_count_t;
endpackage

// File: verilog/atp_regs.svh
// Timing constants for the conversion trigger and pacer logic
`ifndef ATP_REGS_SVH
`define ATP_REGS_SVH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
`define ATP_SYS_CLK_HZ   100000000
`define ATP_TIMEBASE_HZ  10000000
`define ATP_INT_CLK_HZ   1000000

// ----------------------------------------------------------------
// Derived divider counts
// ----------------------------------------------------------------
`define ATP_TB_DIV       (`ATP_SYS_CLK_HZ / `ATP_TIMEBASE_HZ)
`define ATP_INT_DIV      (`ATP_TIMEBASE_HZ / `ATP_INT_CLK_HZ)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ATP_CNT_RESET    16'h0000
`define ATP_DIV_RESET    4'h0

`endif

// File: verilog/atp_trigger_pacer.sv
// Conversion trigger logic with three timer counters and a 32-bit pacer
`timescale 1ns/1ps
`default_nettype none
`include "atp_regs.svh"

module atp_trigger_pacer
(
   input  wire logic               I_SYS_CLK,
   input  wire logic               I_RESETN,
   input  wire logic               i_external_conversion_trigger,
   input  wire logic               i_external_trigger_gate,
   input  wire logic               i_first_counter_clock_input,
   input  wire logic               i_first_counter_gate_input,
   input  wire atp_pkg::atp_src_e  i_trigger_source,
   input  wire logic               i_pacer_enable,
   input  wire atp_pkg::atp_count_t i_pacer_low_reload,
   input  wire atp_pkg::atp_count_t i_pacer_high_reload,
   input  wire atp_pkg::atp_count_t i_first_reload,
   input  wire logic               i_first_clock_external,
   input  wire atp_pkg::atp_mode_e i_first_mode,
   output logic                    o_conversion_start,
   output logic                    o_pacer_output,
   output logic                    o_first_counter_output
);

   localparam logic [3:0] TB_LAST  = 4'(`ATP_TB_DIV - 1);
   localparam logic [3:0] INT_LAST = 4'(`ATP_INT_DIV - 1);

   // Down-count step: returns terminal flag and next count; reload 0 means 65536.
   // A counter not yet loaded since reset takes its reload on its first step, so
   // even the first period follows the programmed value instead of a full wrap.
   function automatic logic [16:0] count_step
   (
      input logic [15:0] cnt,
      input logic [15:0] reload,
      input logic        en,
      input logic        loaded
   );
      logic [16:0] res;
      res = {1'b0, cnt};
      if (en)
      begin
         if (!loaded)
            res = {1'b0, reload};
         else if (cnt == 16'h0001)
            res = {1'b1, reload};
         else
            res = {1'b0, 16'(cnt - 16'h0001)};
      end
      return res;
   endfunction

   // Rising edge of a level against its previous sample
   function automatic logic rise_of
   (
      input logic cur,
      input logic prev
   );
      return cur & ~prev;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [3:0]  tb_div;
   logic [3:0]  int_div;
   logic        tb_tick;
   logic        int_tick;
   logic [2:0]  trg_sync;
   logic [1:0]  gate_sync;
   logic [2:0]  c0clk_sync;
   logic [1:0]  c0gate_sync;
   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic [15:0] cnt2;
   logic        pacer_prev;
   logic [2:0]  loaded;

   logic [3:0]  next_tb_div;
   logic [3:0]  next_int_div;
   logic        next_tb_tick;
   logic        next_int_tick;
   logic [15:0] next_cnt0;
   logic [15:0] next_cnt1;
   logic [15:0] next_cnt2;
   logic        next_conversion_start;
   logic        next_pacer_output;
   logic        next_first_counter_output;
   logic [2:0]  next_loaded;

   logic [16:0] step0;
   logic [16:0] step1;
   logic [16:0] step2;
   logic        c0_event;
   logic        trg_edge;
   logic        pacer_rise;

   // ----------------------------------------------------------------
   // Timebase and counters
   // ----------------------------------------------------------------
   // Timebase dividers, pin edge detection and counter stepping
   always_comb
   begin
      next_tb_div   = (tb_div == TB_LAST) ? `ATP_DIV_RESET : 4'(tb_div + 4'h1);
      next_tb_tick  = (tb_div == TB_LAST);
      next_int_div  = int_div;
      next_int_tick = 1'b0;
      if (tb_tick)
      begin
         next_int_div  = (int_div == INT_LAST) ? `ATP_DIV_RESET : 4'(int_div + 4'h1);
         next_int_tick = (int_div == INT_LAST);
      end
      // Clock choice for the first counter, gated by its gate pin
      c0_event = i_first_clock_external ? rise_of(c0clk_sync[1], c0clk_sync[2])
                                        : int_tick;
      c0_event = c0_event & c0gate_sync[1];
      step0    = count_step(cnt0, i_first_reload, c0_event, loaded[0]);
      step1    = count_step(cnt1, i_pacer_low_reload, tb_tick, loaded[1]);
      step2    = count_step(cnt2, i_pacer_high_reload, step1[16], loaded[2]);
      // A counter holds its programmed reload from its first step on
      next_loaded = loaded | {step1[16], tb_tick, c0_event};
      next_cnt1 = step1[15:0];
      next_cnt2 = step2[15:0];
      next_cnt0 = step0[15:0];
      // Event mode reloads while gated off and latches terminal count
      if (i_first_mode == atp_pkg::ATP_MODE_EVENT)
      begin
         if (!c0gate_sync[1])
         begin
            next_cnt0      = i_first_reload;
            next_loaded[0] = 1'b1;
         end
         next_first_counter_output = c0gate_sync[1] &
                                     (o_first_counter_output | step0[16]);
      end
      else
      begin
         next_first_counter_output = step0[16];
      end
      next_pacer_output = i_pacer_enable & step2[16];
   end

   // ----------------------------------------------------------------
   // Conversion trigger selection
   // ----------------------------------------------------------------
   // Edges of the synchronised trigger pin and of the registered pacer pin;
   // pacer starts follow the pin copy so they always match what is seen outside
   always_comb
   begin
      pacer_rise = rise_of(o_pacer_output, pacer_prev);
      trg_edge   = rise_of(trg_sync[1], trg_sync[2]) & gate_sync[1];
      unique case (i_trigger_source)
         atp_pkg::ATP_SRC_PACER:    next_conversion_start = pacer_rise;
         atp_pkg::ATP_SRC_EXTERNAL: next_conversion_start = trg_edge;
         default:                   next_conversion_start = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Timebase, counter state, counter pin synchronisers and counter pins
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         tb_div                 <= `ATP_DIV_RESET;
         int_div                <= `ATP_DIV_RESET;
         tb_tick                <= 1'b0;
         int_tick               <= 1'b0;
         c0clk_sync             <= 3'h0;
         c0gate_sync            <= 2'h0;
         cnt0                   <= `ATP_CNT_RESET;
         cnt1                   <= `ATP_CNT_RESET;
         cnt2                   <= `ATP_CNT_RESET;
         loaded                 <= 3'h0;
         o_pacer_output         <= 1'b0;
         o_first_counter_output <= 1'b0;
      end
      else
      begin
         tb_div                 <= next_tb_div;
         int_div                <= next_int_div;
         tb_tick                <= next_tb_tick;
         int_tick               <= next_int_tick;
         c0clk_sync             <= {c0clk_sync[1:0], i_first_counter_clock_input};
         c0gate_sync            <= {c0gate_sync[0], i_first_counter_gate_input};
         cnt0                   <= next_cnt0;
         cnt1                   <= next_cnt1;
         cnt2                   <= next_cnt2;
         loaded                 <= next_loaded;
         o_pacer_output         <= next_pacer_output;
         o_first_counter_output <= next_first_counter_output;
      end
   end

   // Trigger synchronisers, pacer pin history and the start pulse; the third
   // trigger stage only serves the edge compare, so no logic sees a metastable bit
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         trg_sync               <= 3'h0;
         gate_sync              <= 2'h0;
         pacer_prev             <= 1'b0;
         o_conversion_start     <= 1'b0;
      end
      else
      begin
         trg_sync               <= {trg_sync[1:0], i_external_conversion_trigger};
         gate_sync              <= {gate_sync[0], i_external_trigger_gate};
         pacer_prev             <= o_pacer_output;
         o_conversion_start     <= next_conversion_start;
      end
   end

endmodule

`default_nettype wire
